/* serial_flash_pin_frontend.sv */
`timescale 1ns/1ps
module serial_flash_pin_frontend #(
  parameter logic [7:0] MODIFY_BASE = 8'h80,
  parameter logic [7:0] MODIFY_MASK = 8'hf0,
  parameter logic [7:0] SPR_WR_OPC  = 8'h90,
  parameter logic [7:0] PROT_EN_OPC = 8'ha0,
  parameter logic [7:0] LOCK_OPC    = 8'ha1
) (
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  // flash pins
  input  wire logic               CS_N,
  input  wire logic               SCK,
  input  wire logic               SI,
  input  wire logic               WP_N,
  input  wire logic               RESET_N,
  output logic                    SO_O,
  output logic                    SO_OE,
  // received bytes to the core
  output logic                    RX_VALID,
  input  wire logic               RX_READY,
  output sflash_pkg::rx_word_type RX_WORD,
  // bytes to send from the core
  input  wire logic               TX_VALID,
  output logic                    TX_READY,
  input  wire logic [7:0]         TX_DATA,
  // core status
  input  wire logic               OP_BUSY,
  output logic                    SELECTED,
  output logic                    STANDBY,
  output logic                    HW_PROTECT,
  output logic                    CMD_DROPPED,
  output logic                    OP_END,
  output logic                    RX_OVERRUN,
  output logic                    CORE_RST
);
  import sflash_pkg::*;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  pins_type s1_q;
  pins_type s2_q;
  pins_type s3_q;
  pins_type pins_now;

  assign pins_now = '{cs_n: CS_N, sck: SCK, si: SI,
                      wp_n: WP_N, rst_n: RESET_N};

  // a floating protect pin settles high at reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s1_q <= PINS_RST;
      s2_q <= PINS_RST;
      s3_q <= PINS_RST;
    end else begin
      s1_q <= pins_now;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic sel;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic wp_on;

  assign sel      = ~s2_q.cs_n;
  assign cs_fall  = ~s2_q.cs_n & s3_q.cs_n;
  assign cs_rise  = s2_q.cs_n & ~s3_q.cs_n;
  assign sck_rise = sel & s2_q.sck & ~s3_q.sck;
  assign sck_fall = sel & ~s2_q.sck & s3_q.sck;
  assign wp_on    = ~s2_q.wp_n;

  // ----------------------------------------------------------
  // power-on and pin reset
  // ----------------------------------------------------------
  logic [3:0] por_q;
  logic [3:0] por_d;
  logic       int_rst;

  always_comb begin
    por_d = por_q;
    if (por_q != POR_CYC) begin
      por_d = por_q + 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      por_q <= 4'h0;
    end else begin
      por_q <= por_d;
    end
  end

  // held for as long as the pin stays low
  assign int_rst  = RST | (por_q != POR_CYC) | ~s2_q.rst_n;
  assign CORE_RST = int_rst;

  // ----------------------------------------------------------
  // opcode classing
  // ----------------------------------------------------------
  logic [7:0] shin;
  logic [7:0] sh_q;
  logic       is_mod;
  logic       exempt;
  logic       guard;

  assign shin   = {sh_q[6:0], s2_q.si};
  assign is_mod = ((shin & MODIFY_MASK) == MODIFY_BASE) ||
                  (shin == SPR_WR_OPC);
  assign exempt = (shin == PROT_EN_OPC) || (shin == LOCK_OPC);
  assign guard  = wp_on & is_mod & ~exempt;

  // ----------------------------------------------------------
  // frame state and shifters
  // ----------------------------------------------------------
  state_type   state_q;
  state_type   state_d;
  logic [7:0]  sh_d;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  logic [7:0]  txsh_q;
  logic [7:0]  txsh_d;
  logic [2:0]  txcnt_q;
  logic [2:0]  txcnt_d;
  logic        so_q;
  logic        so_d;
  logic        oe_q;
  logic        oe_d;
  rx_word_type pend_q;
  rx_word_type pend_d;
  logic        pend_v_q;
  logic        pend_v_d;
  logic        drop_q;
  logic        drop_d;
  logic        end_q;
  logic        end_d;
  logic        ovr_q;
  logic        ovr_d;
  logic        stby_q;
  logic        stby_d;
  logic        buf_in_rdy;
  logic [7:0]  tx_byte;

  always_comb begin
    state_d  = state_q;
    sh_d     = sh_q;
    cnt_d    = cnt_q;
    txsh_d   = txsh_q;
    txcnt_d  = txcnt_q;
    so_d     = so_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    drop_d   = 1'b0;
    end_d    = 1'b0;
    ovr_d    = ovr_q;
    TX_READY = 1'b0;
    tx_byte  = IDLE_OUT;
    if (pend_v_q && buf_in_rdy) begin
      pend_v_d = 1'b0;
    end
    if (cs_fall) begin
      ovr_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        cnt_d   = 3'h0;
        txcnt_d = 3'h0;
        so_d    = 1'b1;
        if (cs_fall) begin
          state_d = ST_OPC;
        end
      end
      ST_OPC, ST_DATA: begin
        if (sck_rise) begin
          sh_d  = shin;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == LAST_BIT) begin
            if (state_q == ST_OPC && guard) begin
              state_d = ST_DROP;
              drop_d  = 1'b1;
            end else begin
              state_d  = ST_DATA;
              ovr_d    = ovr_d | pend_v_d;
              pend_d   = '{first: (state_q == ST_OPC),
                           data: shin};
              pend_v_d = 1'b1;
            end
          end
        end
        if (sck_fall && state_q == ST_DATA) begin
          if (txcnt_q == 3'h0) begin
            TX_READY = TX_VALID;
            tx_byte  = TX_VALID ? TX_DATA : IDLE_OUT;
            so_d     = tx_byte[7];
            txsh_d   = {tx_byte[6:0], 1'b1};
          end else begin
            so_d   = txsh_q[7];
            txsh_d = {txsh_q[6:0], 1'b1};
          end
          txcnt_d = txcnt_q + 3'h1;
        end
      end
      ST_DROP: begin
        // bits of a dropped command are not looked at
        cnt_d = 3'h0;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (cs_rise && state_q != ST_IDLE) begin
      state_d = ST_IDLE;
      end_d   = 1'b1;
    end
    oe_d   = (state_d == ST_DATA);
    // the core keeps its own operation running past deselect
    stby_d = (state_d == ST_IDLE) & ~OP_BUSY;
  end

  always_ff @(posedge SYS_CLK) begin
    if (int_rst) begin
      state_q  <= ST_IDLE;
      sh_q     <= 8'h00;
      cnt_q    <= 3'h0;
      txsh_q   <= IDLE_OUT;
      txcnt_q  <= 3'h0;
      so_q     <= 1'b1;
      oe_q     <= 1'b0;
      pend_q   <= '0;
      pend_v_q <= 1'b0;
      drop_q   <= 1'b0;
      end_q    <= 1'b0;
      ovr_q    <= 1'b0;
      stby_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      sh_q     <= sh_d;
      cnt_q    <= cnt_d;
      txsh_q   <= txsh_d;
      txcnt_q  <= txcnt_d;
      so_q     <= so_d;
      oe_q     <= oe_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      drop_q   <= drop_d;
      end_q    <= end_d;
      ovr_q    <= ovr_d;
      stby_q   <= stby_d;
    end
  end

  assign SO_O        = so_q;
  assign SO_OE       = oe_q;
  assign SELECTED    = sel;
  assign STANDBY     = stby_q;
  assign HW_PROTECT  = wp_on;
  assign CMD_DROPPED = drop_q;
  assign OP_END      = end_q;
  assign RX_OVERRUN  = ovr_q;

  // ----------------------------------------------------------
  // two-entry receive buffer
  // ----------------------------------------------------------
  // the host clock cannot be stalled, so a full buffer
  // holds the pending byte until a newer one replaces it and flags overrun
  rx_word_type mem_q [2];
  rx_word_type mem_d [2];
  logic        wr_q;
  logic        wr_d;
  logic        rd_q;
  logic        rd_d;
  logic [1:0]  bcnt_q;
  logic [1:0]  bcnt_d;
  logic        push;
  logic        pop;

  assign buf_in_rdy = (bcnt_q != BUF_FULL);
  assign push       = pend_v_q & buf_in_rdy;
  assign pop        = RX_VALID & RX_READY;
  assign RX_VALID   = (bcnt_q != 2'h0);
  assign RX_WORD    = mem_q[rd_q];

  always_comb begin
    mem_d  = mem_q;
    wr_d   = wr_q;
    rd_d   = rd_q;
    bcnt_d = bcnt_q;
    if (push) begin
      mem_d[wr_q] = pend_q;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    bcnt_d = bcnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge SYS_CLK) begin
    if (int_rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      bcnt_q   <= 2'h0;
    end else begin
      mem_q    <= mem_d;
      wr_q     <= wr_d;
      rd_q     <= rd_d;
      bcnt_q   <= bcnt_d;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  property p_desel_hiz;
    @(posedge SYS_CLK) disable iff (int_rst)
    s2_q.cs_n |=> !SO_OE && (stby_q == !$past(OP_BUSY));
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("output driven while deselected");

  property p_desel_ignore;
    @(posedge SYS_CLK) disable iff (int_rst)
    (s2_q.cs_n && s3_q.cs_n) |=> $stable(sh_q) && !$rose(pend_v_q);
  endproperty
  a_desel_ignore: assert property (p_desel_ignore)
    else $error("input taken while deselected");

  property p_start_fall;
    @(posedge SYS_CLK) disable iff (int_rst)
    (state_q == ST_IDLE) ##1 (state_q == ST_OPC) |-> $past(cs_fall);
  endproperty
  a_start_fall: assert property (p_start_fall)
    else $error("frame began without select fall");

  property p_end_rise;
    @(posedge SYS_CLK) disable iff (int_rst)
    (state_q != ST_IDLE) ##1 (state_q == ST_IDLE) |->
      $past(cs_rise) && OP_END;
  endproperty
  a_end_rise: assert property (p_end_rise)
    else $error("frame ended without select rise");

  property p_busy_stby;
    @(posedge SYS_CLK) disable iff (int_rst)
    OP_BUSY |=> !STANDBY;
  endproperty
  a_busy_stby: assert property (p_busy_stby)
    else $error("standby while operation runs");

  property p_sample_rise;
    @(posedge SYS_CLK) disable iff (int_rst)
    (sck_rise && state_q == ST_OPC) |=>
      sh_q == {$past(sh_q[6:0]), $past(s2_q.si)};
  endproperty
  a_sample_rise: assert property (p_sample_rise)
    else $error("input bit not shifted on rise");

  property p_out_fall;
    @(posedge SYS_CLK) disable iff (int_rst)
    ($changed(so_q) && $past(state_q == ST_DATA)) |-> $past(sck_fall);
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("output changed off a falling edge");

  property p_opc_len;
    @(posedge SYS_CLK) disable iff (int_rst)
    $rose(state_q == ST_DATA) |-> cnt_q == 3'h0 && pend_v_q &&
      pend_q.first && pend_q.data == sh_q;
  endproperty
  a_opc_len: assert property (p_opc_len)
    else $error("opcode not eight bits");

  property p_guard;
    @(posedge SYS_CLK) disable iff (int_rst)
    (state_q == ST_OPC && sck_rise && cnt_q == LAST_BIT && guard
      && !cs_rise) |=> state_q == ST_DROP && CMD_DROPPED && !pend_v_q;
  endproperty
  a_guard: assert property (p_guard)
    else $error("guarded command not dropped");

  property p_exempt;
    @(posedge SYS_CLK) disable iff (int_rst)
    (state_q == ST_OPC && sck_rise && cnt_q == LAST_BIT && wp_on
      && exempt && !cs_rise) |=> state_q == ST_DATA;
  endproperty
  a_exempt: assert property (p_exempt)
    else $error("exempt opcode refused");

  property p_pin_rst;
    @(posedge SYS_CLK) disable iff (RST)
    !s2_q.rst_n |-> CORE_RST ##1 (state_q == ST_IDLE && !SO_OE);
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin reset did not force idle");

  property p_por;
    @(posedge SYS_CLK)
    $fell(RST) |-> CORE_RST [*4];
  endproperty
  a_por: assert property (p_por)
    else $error("power-on reset too short");

  c_cmd: cover property (@(posedge SYS_CLK) disable iff (int_rst)
    $rose(state_q == ST_DATA) ##[1:400] OP_END);
  c_drop: cover property (@(posedge SYS_CLK) disable iff (int_rst)
    CMD_DROPPED);
  c_ovr: cover property (@(posedge SYS_CLK) disable iff (int_rst)
    $rose(RX_OVERRUN));
  c_busy: cover property (@(posedge SYS_CLK) disable iff (int_rst)
    OP_END ##1 OP_BUSY [*3] ##1 STANDBY);

endmodule : serial_flash_pin_frontend

/* serial_flash_pin_interface_bench.sv */
`timescale 1ns/1ps
module serial_flash_pin_interface_bench;
  import sflash_pkg::*;
  logic        sys_clk, rst, wp_drv, wp_val, reset_n;
  logic        rx_ready, tx_valid, op_busy;
  logic [7:0]  tx_data, r;
  wire logic   cs_n, sck, si, so_o, so_oe, wp_n;
  logic        rx_valid, tx_ready, selected, standby, hw_protect;
  logic        cmd_dropped, op_end, rx_overrun, core_rst;
  rx_word_type rx_word;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          drops = 0;
  int          ends = 0;
  int          txs = 0;
  int          d0, e0, t0;
  // pull-up on the protect pin when nobody drives it
  assign wp_n = wp_drv ? wp_val : 1'b1;
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // counted mid-cycle so a task resuming on a rising edge sees the total
  always @(negedge sys_clk) begin
    if (cmd_dropped === 1'b1) drops <= drops + 1;
    if (op_end === 1'b1) ends <= ends + 1;
    if (tx_ready === 1'b1) txs <= txs + 1;
  end
  spi_host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
                       .so_o(so_o), .so_oe(so_oe));
  serial_flash_pin_frontend DUT (
    .SYS_CLK(sys_clk), .RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si),
    .WP_N(wp_n), .RESET_N(reset_n), .SO_O(so_o), .SO_OE(so_oe),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_WORD(rx_word),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .OP_BUSY(op_busy), .SELECTED(selected), .STANDBY(standby),
    .HW_PROTECT(hw_protect), .CMD_DROPPED(cmd_dropped), .OP_END(op_end),
    .RX_OVERRUN(rx_overrun), .CORE_RST(core_rst));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic wait_idle;
    int k;
    for (k = 0; k < 100 && standby !== 1'b1; k++) @(posedge sys_clk);
    if (k == 100) begin
      n_mismatch++;
      test_done();
    end
  endtask : wait_idle
  task automatic pop(input rx_word_type exp);
    @(posedge sys_clk);
    check(rx_valid, 1'b1);
    check(rx_word, exp);
    rx_ready <= 1'b1;
    @(posedge sys_clk);
    rx_ready <= 1'b0;
  endtask : pop
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_idle;
    check({standby, so_oe, selected, rx_valid}, 4'h8);
    host.xfer(8'h0b, r); // nobody selected, clock and data toggle
    check({rx_valid, selected, so_oe}, 3'h0);
    $display("t_idle done");
  endtask : t_idle
  task automatic t_frame;
    t0 = txs;
    host.sel(1'b0);
    check(selected, 1'b1);
    host.xfer(8'h0b, r);
    host.xfer(8'h5a, r);
    check(r, 8'hc3);
    check(so_oe, 1'b1);
    host.xfer(8'h3c, r); // third byte waits behind a full buffer
    check(r, 8'hc3);
    e0 = ends;
    host.sel(1'b1);
    check(16'(ends - e0), 16'h1);
    check(16'(txs - t0), 16'h3);
    check({so_oe, rx_overrun}, 2'h0);
    pop({1'b1, 8'h0b});
    pop({1'b0, 8'h5a});
    pop({1'b0, 8'h3c});
    @(posedge sys_clk);
    check(rx_valid, 1'b0);
    $display("t_frame done");
  endtask : t_frame
  task automatic t_wp;
    logic [7:0] ops [5] = '{8'h82, 8'h90, 8'ha0, 8'ha1, 8'h0b};
    logic       dr [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    rx_ready <= 1'b1;
    wp_drv   <= 1'b1;
    wp_val   <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (i == 5) wp_drv <= 1'b0; // released pin, guarded opcode again
      d0 = drops;
      host.sel(1'b0);
      check(hw_protect, (i < 5));
      host.xfer((i < 5) ? ops[i] : 8'h82, r);
      host.xfer(8'h00, r);
      host.sel(1'b1);
      check(16'(drops - d0), (i < 5) ? dr[i] : 1'b0);
      wait_idle();
      check(standby, 1'b1);
    end
    $display("t_wp done");
  endtask : t_wp
  task automatic t_busy;
    op_busy  <= 1'b1;
    tx_valid <= 1'b0;
    t0 = txs;
    host.sel(1'b0);
    host.xfer(8'h82, r);
    host.xfer(8'h00, r);
    check(r, 8'hff);
    host.sel(1'b1);
    check(16'(txs - t0), 16'h0);
    tx_valid <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check(standby, 1'b0);
    op_busy <= 1'b0;
    wait_idle();
    check(standby, 1'b1);
    $display("t_busy done");
  endtask : t_busy
  task automatic t_pin_reset;
    rx_ready <= 1'b0;
    tx_data  <= 8'h96;
    host.sel(1'b0);
    host.xfer(8'h0b, r);
    host.xfer(8'h11, r);
    check(r, 8'h96);
    check(so_oe, 1'b1);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({core_rst, so_oe, rx_valid}, 3'h4);
    repeat (20) @(posedge sys_clk);
    check({core_rst, standby}, 2'h2);
    reset_n <= 1'b1;
    host.sel(1'b1);
    wait_idle();
    check(core_rst, 1'b0);
    host.sel(1'b0);
    host.xfer(8'ha0, r);
    host.sel(1'b1);
    pop({1'b1, 8'ha0});
    $display("t_pin_reset done");
  endtask : t_pin_reset
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    rst      = 1'b1;
    wp_drv   = 1'b0;
    wp_val   = 1'b1;
    reset_n  = 1'b1;
    rx_ready = 1'b0;
    tx_valid = 1'b1;
    tx_data  = 8'hc3;
    op_busy  = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    check(core_rst, 1'b1);
    wait_idle();
    t_idle();
    t_frame();
    t_wp();
    t_busy();
    t_pin_reset();
    test_done();
  end
endmodule : serial_flash_pin_interface_bench

/* sflash_pkg.sv */
package sflash_pkg;

  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int POR_NS = 100;
  localparam int POR_CYC_I = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] POR_CYC = 4'(POR_CYC_I);

  // ----------------------------------------------------------
  // framing
  // ----------------------------------------------------------
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] IDLE_OUT = 8'hff;
  localparam logic [1:0] BUF_FULL = 2'h2;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic rst_n;
  } pins_type;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } rx_word_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPC  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DROP = 4'b1000
  } state_type;

  // pins at rest: deselected, unprotected, out of reset
  localparam pins_type PINS_RST = 5'b10011;

endpackage : sflash_pkg

/* spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic sys_clk,
  // flash pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe
);
  logic so_last = 1'b1;
  logic so_w;
  // a released line shows the inverse of its last level, never a held value
  always @(posedge sys_clk) if (so_oe === 1'b1) so_last <= so_o;
  assign so_w = (so_oe === 1'b1) ? so_o : ~so_last;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // mode 0: clock rests low outside frames
  task automatic sel(input logic v);
    repeat (4) @(posedge sys_clk);
    cs_n <= v;
    repeat (4) @(posedge sys_clk);
  endtask : sel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      repeat (4) @(posedge sys_clk);
      sck <= 1'b1;
      // capture one cycle into the high phase, output stands until the fall
      @(posedge sys_clk);
      rx[i] = so_w;
      repeat (3) @(posedge sys_clk);
      sck <= 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model
